// *** src/toh_insert_port.sv ***
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
`include "toh_map.svh"

module toh_insert_port
  import toh_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        tx_system_input_clock_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [8:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  tx_tributary_ref_clock_a_i,
  output logic      [2:0]  tx_overhead_clock_out_o,
  input  wire logic [2:0]  tx_overhead_data_in_i,
  input  wire logic [2:0]  tx_overhead_insert_request_i,
  output logic      [2:0]  tx_overhead_frame_marker_o,
  output logic      [2:0]  tx_overhead_slot_indicator_o,
  output logic      [2:0]  framer_tick_o,
  output logic      [2:0]  framer_ref_sel_o
);

  toh_sys_t  s;
  toh_sys_t  next_s;
  toh_lnk_t  l;
  toh_lnk_t  next_l;

  logic        ram_we;
  logic [5:0]  ram_waddr;
  logic [7:0]  ram_wdata;
  logic [2:0]  ref_sel;
  logic        req;

  toh_ram_if rif();

  toh_ovh_ram u_ram (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .bus   (rif.mem)
  );

  function automatic logic chf(logic [31:0] v, int ch, int f);
    return v[ch * `TOH_CH_STRIDE + f];
  endfunction

  function automatic logic is_ram(logic [8:0] adr);
    return adr[`TOH_RAM_BIT];
  endfunction

  function automatic logic [31:0] put_sel(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // One link cycle of one channel's overhead port
  function automatic toh_lch_t lch_step(toh_lch_t c, logic [3:0] m, logic [7:0] dv,
                                        logic ins, logic dat);
    toh_lch_t   n;
    logic       sts;
    logic       fall;
    logic       rise;
    logic       take;
    logic       bitv;
    logic [6:0] last;
    logic [6:0] npos;
    logic [7:0] nshf;
    n    = c;
    sts  = m[`TOH_F_STS1];
    fall = (c.cnt == `TOH_OHCLK_LAST);
    rise = (c.cnt == `TOH_OHCLK_RISE);
    last = sts ? `TOH_STS_LAST : `TOH_DS3_LAST;
    // Out-of-range position wraps at once, so enabling starts a clean frame
    npos = (c.pos >= last) ? 7'h00 : c.pos + 7'h01;
    n.ins_sy = {c.ins_sy[0], ins};
    n.dat_sy = {c.dat_sy[0], dat};
    if (!m[`TOH_F_EN]) begin
      n.cnt   = 3'h0;
      n.pos   = `TOH_STS_LAST;
      n.ohclk = 1'b0;
      n.slot  = 1'b0;
      n.frame = 1'b0;
      n.bitn  = 3'h0;
      n.bidx  = 4'h0;
      n.shf   = 8'h00;
    end else begin
      n.cnt   = c.cnt + 3'h1;
      n.ohclk = n.cnt[2];
      if (sts) begin
        n.slot  = fall ? (npos < `TOH_STS_POH_BITS) : c.slot;
        n.frame = fall ? (npos == 7'h00) : c.frame;
      end else begin
        // One system clock wide, ahead of the fall that samples
        n.slot  = rise && (c.pos == 7'h00);
        n.frame = 1'b0;
      end
      take = fall && (sts ? c.slot : (c.pos == 7'h00));
      bitv = c.ins_sy[1] ? c.dat_sy[1] : dv[3'h7 - c.bitn];
      nshf = {c.shf[6:0], bitv};
      if (fall) begin
        n.pos = npos;
      end
      if (take) begin
        n.shf  = nshf;
        n.bitn = c.bitn + 3'h1;
        if (c.bitn == 3'h7) begin
          n.word = {c.bidx, nshf};
          n.tgl  = ~c.tgl;
          n.bidx = (c.bidx == `TOH_POH_LAST) ? 4'h0 : c.bidx + 4'h1;
        end
      end
      // Byte alignment restarts with every STS-1 overhead frame
      if (sts && fall && (npos == 7'h00)) begin
        n.bitn = 3'h0;
        n.bidx = 4'h0;
      end
    end
    return n;
  endfunction

  // Link domain: overhead port, clocked by the system input clock
  always_comb begin
    next_l      = l;
    next_l.rsy  = {l.rsy[0], rst_i};
    next_l.cesy = {l.cesy[0], ce_i};
    if (l.rsy[1]) begin
      next_l      = '0;
      next_l.rsy  = {l.rsy[0], rst_i};
      next_l.cesy = {l.cesy[0], ce_i};
      next_l.ctrl = 12'(`TOH_CTRL_RST);
      next_l.dflt = 24'(`TOH_DFLT_RST);
    end else if (l.cesy[1]) begin
      next_l.cfg_sy = {l.cfg_sy[1:0], s.cfg_tgl};
      // Settings are held steady on the bus side once the toggle moves
      if (l.cfg_sy[2] != l.cfg_sy[1]) begin
        next_l.ctrl = s.ctrl[11:0];
        next_l.dflt = s.dflt[23:0];
      end
      for (int c = 0; c < 3; c++) begin
        next_l.ch[c] = lch_step(l.ch[c], l.ctrl[c*`TOH_CH_STRIDE +: 4], l.dflt[c*8 +: 8],
                                tx_overhead_insert_request_i[c], tx_overhead_data_in_i[c]);
      end
    end
  end

  always_ff @(posedge tx_system_input_clock_i) begin
    l <= next_l;
  end

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      tx_overhead_clock_out_o[c]      = l.ch[c].ohclk;
      tx_overhead_slot_indicator_o[c] = l.ch[c].slot;
      tx_overhead_frame_marker_o[c]   = l.ch[c].frame;
    end
  end

  // Bus domain
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      ref_sel[c] = chf(s.ctrl, c, `TOH_F_ATM) && chf(s.ctrl, c, `TOH_F_LOCAL);
    end
  end

  assign req = wb_cyc_i && wb_stb_i;

  always_comb begin
    next_s    = s;
    ram_we    = 1'b0;
    ram_waddr = 6'h00;
    ram_wdata = 8'h00;
    if (ce_i) begin
      next_s.bt_s1 = {l.ch[2].tgl, l.ch[1].tgl, l.ch[0].tgl};
      next_s.bt_s2 = s.bt_s1;
      next_s.bt_s3 = s.bt_s2;
      next_s.rf_s1 = tx_tributary_ref_clock_a_i;
      next_s.rf_s2 = s.rf_s1;
      next_s.rf_s3 = s.rf_s2;
      next_s.itk   = (s.itk == `TOH_INT_TICK_LAST) ? 2'h0 : s.itk + 2'h1;
      for (int c = 0; c < 3; c++) begin
        // Reference clock has no effect unless selected
        next_s.tick[c] = ref_sel[c] ? (s.rf_s2[c] && !s.rf_s3[c])
                                    : (s.itk == `TOH_INT_TICK_LAST);
      end
      // One RAM write per cycle; channels bring a byte far apart
      for (int c = 2; c >= 0; c--) begin
        if (s.pend[c]) begin
          ram_we    = 1'b1;
          ram_waddr = {2'(c), s.pdat[c][11:8]};
          ram_wdata = s.pdat[c][7:0];
        end
      end
      for (int c = 0; c < 3; c++) begin
        if (ram_we && (ram_waddr[5:4] == 2'(c))) begin
          next_s.pend[c] = 1'b0;
        end
      end
      if (ram_we) begin
        next_s.nbytes = s.nbytes + 8'h01;
      end
      // A new byte sets pending after any clear
      for (int c = 0; c < 3; c++) begin
        if (s.bt_s3[c] != s.bt_s2[c]) begin
          next_s.pend[c] = 1'b1;
          next_s.pdat[c] = l.ch[c].word;
        end
      end
      case (s.st)
        TOH_BUS_IDLE: begin
          if (req) begin
            next_s.st = TOH_BUS_WAIT;
          end
        end
        TOH_BUS_WAIT: begin
          next_s.st = req ? TOH_BUS_ACK : TOH_BUS_IDLE;
          if (is_ram(wb_adr_i)) begin
            next_s.rdat = {24'h000000, rif.rdata};
          end else begin
            case ({wb_adr_i[8:2], 2'h0})
              `TOH_ADR_CTRL: next_s.rdat = s.ctrl;
              `TOH_ADR_DFLT: next_s.rdat = s.dflt;
              `TOH_ADR_STAT: begin
                next_s.rdat = 32'h0000_0000;
                next_s.rdat[2:0] = ref_sel;
                next_s.rdat[`TOH_STAT_CNT_LSB +: 8] = s.nbytes;
              end
              default: next_s.rdat = 32'h0000_0000;
            endcase
          end
        end
        TOH_BUS_ACK: begin
          next_s.st = TOH_BUS_IDLE;
          if (req && wb_we_i && !is_ram(wb_adr_i)) begin
            case ({wb_adr_i[8:2], 2'h0})
              `TOH_ADR_CTRL: begin
                next_s.ctrl    = put_sel(s.ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0fff;
                next_s.cfg_tgl = ~s.cfg_tgl;
              end
              `TOH_ADR_DFLT: begin
                next_s.dflt    = put_sel(s.dflt, wb_dat_i, wb_sel_i) & 32'h00ff_ffff;
                next_s.cfg_tgl = ~s.cfg_tgl;
              end
              default: next_s.st = TOH_BUS_IDLE;
            endcase
          end
        end
        default: next_s.st = TOH_BUS_IDLE;
      endcase
    end
    if (rst_i) begin
      next_s      = '0;
      next_s.ctrl = `TOH_CTRL_RST;
      next_s.dflt = `TOH_DFLT_RST;
      ram_we      = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign rif.we    = ram_we;
  assign rif.waddr = ram_waddr;
  assign rif.wdata = ram_wdata;
  assign rif.raddr = wb_adr_i[7:2];

  assign wb_ack_o         = (s.st == TOH_BUS_ACK);
  assign wb_dat_o         = s.rdat;
  assign framer_tick_o    = s.tick;
  assign framer_ref_sel_o = ref_sel;

endmodule

// *** src/toh_map.svh ***
`ifndef TOH_MAP_SVH
`define TOH_MAP_SVH

// Register byte addresses on the Wishbone bus, and the address bit that selects the RAM
`define TOH_ADR_CTRL      9'h000
`define TOH_ADR_DFLT      9'h004
`define TOH_ADR_STAT      9'h008
`define TOH_RAM_BIT       8

// Reset values
`define TOH_CTRL_RST      32'h0000_0000
`define TOH_DFLT_RST      32'h0000_0000

// Per-channel control nibble
`define TOH_CH_STRIDE     4
`define TOH_F_STS1        0
`define TOH_F_ATM         1
`define TOH_F_LOCAL       2
`define TOH_F_EN          3

// Status fields
`define TOH_STAT_CNT_LSB  8

// Overhead clock: eight link cycles per period, rising after cycle 3, falling after cycle 7
`define TOH_OHCLK_RISE    3'h3
`define TOH_OHCLK_LAST    3'h7

// Overhead schedule in overhead clock periods, except TOH_POH_LAST, which is a POH byte index
`define TOH_DS3_LAST      7'h07
`define TOH_STS_LAST      7'h5f
`define TOH_STS_POH_BITS  7'h48
`define TOH_POH_LAST      4'h8

// Internal framer timing divider on clk_i
`define TOH_INT_TICK_LAST 2'h2

`endif

// *** src/toh_ovh_ram.sv ***
`timescale 1ns/1ps

module toh_ovh_ram
  import toh_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  toh_ram_if.mem    bus
);

  toh_ram_t r;
  toh_ram_t next_r;

  always_comb begin
    next_r = r;
    if (ce_i) begin
      next_r.rdata = r.mem[bus.raddr];
      if (bus.we) begin
        next_r.mem[bus.waddr] = bus.wdata;
      end
    end
  end

  assign bus.rdata = r.rdata;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// *** src/toh_pkg.sv ***
`include "toh_map.svh"

package toh_pkg;

  typedef enum logic [1:0] {
    TOH_BUS_IDLE = 2'h0,
    TOH_BUS_WAIT = 2'h1,
    TOH_BUS_ACK  = 2'h3
  } toh_bus_st_t;

  typedef struct packed {
    logic [2:0]  cnt;
    logic [6:0]  pos;
    logic        ohclk;
    logic        slot;
    logic        frame;
    logic [2:0]  bitn;
    logic [3:0]  bidx;
    logic [7:0]  shf;
    logic [11:0] word;
    logic        tgl;
    logic [1:0]  ins_sy;
    logic [1:0]  dat_sy;
  } toh_lch_t;

  typedef struct packed {
    logic [1:0]       rsy;
    logic [1:0]       cesy;
    logic [2:0]       cfg_sy;
    logic [11:0]      ctrl;
    logic [23:0]      dflt;
    toh_lch_t [2:0]   ch;
  } toh_lnk_t;

  typedef struct packed {
    logic [31:0]       ctrl;
    logic [31:0]       dflt;
    logic [31:0]       rdat;
    toh_bus_st_t       st;
    logic              cfg_tgl;
    logic [2:0]        bt_s1;
    logic [2:0]        bt_s2;
    logic [2:0]        bt_s3;
    logic [2:0]        pend;
    logic [2:0][11:0]  pdat;
    logic [2:0]        rf_s1;
    logic [2:0]        rf_s2;
    logic [2:0]        rf_s3;
    logic [1:0]        itk;
    logic [2:0]        tick;
    logic [7:0]        nbytes;
  } toh_sys_t;

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [7:0]       rdata;
  } toh_ram_t;

endpackage

// *** src/toh_ram_if.sv ***
`timescale 1ns/1ps

interface toh_ram_if;
  logic       we;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic [5:0] raddr;
  logic [7:0] rdata;

  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** test/tb_toh_insert_port.sv ***
`timescale 1ns/1ps
`include "toh_map.svh"
module tb_toh_insert_port;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        lclk   = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we  = 1'b0;
  logic [8:0]  wb_adr = 9'h000;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic        wb_ack_o;
  logic [2:0]  ref_clk, ohclk, oh_dat, oh_req, frame, slot, tick, rsel;
  logic [2:0]  ins_en = 3'h0;
  int          failures = 0;
  int          n_compared = 0;
  int          nref = 0;
  int          ntk, tk0, i;

  initial forever #4 clk_i = ~clk_i;
  initial begin
    #3;
    forever #16 lclk = ~lclk;
  end

  toh_insert_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .tx_system_input_clock_i(lclk),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_tributary_ref_clock_a_i(ref_clk),
    .tx_overhead_clock_out_o(ohclk), .tx_overhead_data_in_i(oh_dat), .tx_overhead_insert_request_i(oh_req),
    .tx_overhead_frame_marker_o(frame), .tx_overhead_slot_indicator_o(slot), .framer_tick_o(tick),
    .framer_ref_sel_o(rsel));
  toh_far_end i_far (.lclk_i(lclk), .ohclk_i(ohclk), .slot_i(slot), .frame_i(frame), .en_i(ins_en),
    .data_o(oh_dat), .req_o(oh_req), .ref_o(ref_clk));

  always @(posedge ref_clk[2]) nref++;

  task finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Entered just after a rising edge; holds the request until ack is sampled
  task xfer(input logic we, input logic [8:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) failures++;
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task rd_chk(input string nm, input logic [8:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    check(nm, q, e);
  endtask

  initial begin
    #200000;
    failures++;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", `TOH_ADR_CTRL, 32'h0);
    rd_chk("dflt reset", `TOH_ADR_DFLT, 32'h0);
    ins_en <= 3'b011;
    xfer(1'b1, `TOH_ADR_CTRL, 32'hffff_fe89, 4'hf);
    xfer(1'b1, `TOH_ADR_DFLT, 32'hffa5_00c5, 4'hf);
    xfer(1'b1, 9'h00c, 32'hffff_ffff, 4'hf);
    rd_chk("ctrl", `TOH_ADR_CTRL, 32'h0000_0e89);
    rd_chk("dflt", `TOH_ADR_DFLT, 32'h00a5_00c5);
    rd_chk("unmapped", 9'h00c, 32'h0);
    xfer(1'b0, `TOH_ADR_STAT, 32'h0, 4'h0);
    check("stat ref sel", {29'h0, q[2:0]}, 32'h4);
    check("ref sel pins", {29'h0, rsel}, 32'h4);
    $display("test registers done");
    i = nref;
    ntk = 0;
    tk0 = 0;
    repeat (999) begin
      @(posedge clk_i);
      if (tick[2] === 1'b1) ntk++;
      if (tick[0] === 1'b1) tk0++;
    end
    check("ref ticks", 32'((nref - i - ntk) inside {[-2:2]}), 32'h1);
    check("own ticks", 32'(tk0 == 333), 32'h1);
    $display("test reference clock done");
    repeat (6000) @(posedge clk_i);
    for (i = 0; i < 9; i++) rd_chk("sts byte", 9'h100 + 9'(4 * i), 32'(8'h30 + 8'(i)));
    rd_chk("ds3 byte", 9'h140, 32'h0000_00ff);
    $display("test insert done");
    ins_en <= 3'b000;
    repeat (6500) @(posedge clk_i);
    for (i = 0; i < 9; i++) rd_chk("default byte", 9'h100 + 9'(4 * i), 32'h0000_00c5);
    $display("test default done");
    finish_test;
  end
endmodule

// *** test/toh_far_end.sv ***
`timescale 1ns/1ps
module toh_far_end (
  input  wire logic       lclk_i,
  input  wire logic [2:0] ohclk_i,
  input  wire logic [2:0] slot_i,
  input  wire logic [2:0] frame_i,
  input  wire logic [2:0] en_i,
  output logic      [2:0] data_o,
  output logic      [2:0] req_o,
  output logic      [2:0] ref_o
);
  logic [2:0]  prev;
  logic [7:0]  byt;
  int unsigned pos;

  initial begin
    data_o = 3'h0;
    req_o = 3'h0;
    ref_o = 3'h0;
    prev = 3'h0;
    pos = 0;
  end

  always #14.548 ref_o[1:0] = ~ref_o[1:0];
  always #11.177 ref_o[2] = ~ref_o[2];

  // Changes half a link cycle after an overhead clock edge (ch2 every link cycle), far from the next sampling point
  always @(negedge lclk_i) begin
    if (prev[0] && !ohclk_i[0]) begin
      pos = frame_i[0] ? 0 : pos + 1;
      byt = 8'h30 + 8'(pos / 8);
      req_o[0] <= en_i[0] && slot_i[0];
      data_o[0] <= slot_i[0] ? byt[7 - pos % 8] : ~data_o[0];
    end
    if (slot_i[1]) begin
      req_o[1] <= en_i[1];
      data_o[1] <= 1'b1;
    end else if (prev[1] && !ohclk_i[1]) begin
      req_o[1] <= 1'b0;
      data_o[1] <= 1'b0;
    end
    data_o[2] <= ~data_o[2];
    prev = ohclk_i;
  end
endmodule

// *** test/toh_insert_port_properties.sv ***
`timescale 1ns/1ps
module toh_insert_port_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       tx_system_input_clock_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [2:0] tx_tributary_ref_clock_a_i,
  input wire logic [2:0] tx_overhead_clock_out_o,
  input wire logic [2:0] tx_overhead_frame_marker_o,
  input wire logic [2:0] tx_overhead_slot_indicator_o,
  input wire logic [2:0] framer_tick_o,
  input wire logic [2:0] framer_ref_sel_o
);
  // Bench runs ch0 as STS-1, ch1 as DS3, ch2 as ATM local
  wire logic [2:0] ohc = tx_overhead_clock_out_o;
  wire logic [2:0] frm = tx_overhead_frame_marker_o;
  wire logic [2:0] slt = tx_overhead_slot_indicator_o;

  a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wb_cyc_i && wb_stb_i) && ce_i |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack latency wrong");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_has_req: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack without request");
  a_tick_self_timed: assert property (@(posedge clk_i) disable iff (rst_i)
    framer_tick_o[0] && !framer_ref_sel_o[0] |=> !framer_tick_o[0] ##1 !framer_tick_o[0] ##1 framer_tick_o[0])
    else $error("internal tick spacing wrong");
  a_tick_on_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_tributary_ref_clock_a_i[2]) && framer_ref_sel_o[2] && $past(framer_ref_sel_o[2], 4)
    |-> ##[1:4] framer_tick_o[2]) else $error("reference edge gave no tick");
  a_ohclk_high_four: assert property (@(posedge tx_system_input_clock_i) disable iff (rst_i)
    $rose(ohc[0]) |-> ohc[0][*4] ##1 !ohc[0]) else $error("overhead clock high time wrong");
  a_frame_on_fall: assert property (@(posedge tx_system_input_clock_i) disable iff (rst_i)
    $changed(frm[0]) |-> $fell(ohc[0])) else $error("frame marker moved off a clock fall");
  a_slot_on_fall: assert property (@(posedge tx_system_input_clock_i) disable iff (rst_i)
    $changed(slt[0]) |-> $fell(ohc[0])) else $error("slot moved off a clock fall");
  a_slot_with_frame: assert property (@(posedge tx_system_input_clock_i) disable iff (rst_i)
    $rose(slt[0]) |-> $rose(frm[0])) else $error("slot window not at frame start");
  a_frame_one_period: assert property (@(posedge tx_system_input_clock_i) disable iff (rst_i)
    $rose(frm[0]) |-> frm[0][*8] ##1 !frm[0]) else $error("frame marker width wrong");
  a_ds3_slot_pulse: assert property (@(posedge tx_system_input_clock_i) disable iff (rst_i)
    $rose(slt[1]) |-> $rose(ohc[1]) ##1 !slt[1]) else $error("slot pulse wrong");
  a_ds3_slot_lead: assert property (@(posedge tx_system_input_clock_i) disable iff (rst_i)
    $rose(slt[1]) |-> ##4 $fell(ohc[1])) else $error("sampling fall not after slot");
endmodule

bind toh_insert_port toh_insert_port_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .tx_system_input_clock_i(tx_system_input_clock_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .tx_tributary_ref_clock_a_i(tx_tributary_ref_clock_a_i),
  .tx_overhead_clock_out_o(tx_overhead_clock_out_o), .tx_overhead_frame_marker_o(tx_overhead_frame_marker_o),
  .tx_overhead_slot_indicator_o(tx_overhead_slot_indicator_o), .framer_tick_o(framer_tick_o),
  .framer_ref_sel_o(framer_ref_sel_o));
